// file: core/rrgd_pkg.sv
// register map, field positions and reset values for the regulator /
// strength / gain display register bank
// assumes an 8-bit register port with a 6-bit address, one access per cycle
package rrgd_pkg;
    localparam int          DATA_W          = 8;
    localparam int          ADDR_W          = 6;
    localparam int          CODE_W          = 4;
    // register addresses
    localparam logic [5:0]  ADDR_REG_CTRL   = 6'h2a;
    localparam logic [5:0]  ADDR_REG_DISP   = 6'h2b;
    localparam logic [5:0]  ADDR_STRENGTH   = 6'h2c;
    localparam logic [5:0]  ADDR_GAIN_CUT   = 6'h2d;
    localparam logic [5:0]  ADDR_RSVD_A     = 6'h2e;
    localparam logic [5:0]  ADDR_RSVD_B     = 6'h2f;
    // control register fields
    localparam int          CTRL_SRC_BIT    = 7;
    localparam int          CTRL_CODE_HI    = 6;
    localparam int          CTRL_CODE_LO    = 3;
    localparam int          CTRL_MEAS_HI    = 2;
    localparam int          CTRL_MEAS_LO    = 1;
    localparam logic [7:0]  CTRL_WR_MASK    = 8'hfe;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    // effective regulator code after reset: maximum setting
    localparam logic [3:0]  REG_CODE_MAX    = 4'hf;
    localparam logic [3:0]  CODE_ZERO       = 4'h0;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    // measure-supply sources
    typedef enum logic [1:0] {
        RRGD_MEAS_MAIN    = 2'h0,
        RRGD_MEAS_ANALOG  = 2'h1,
        RRGD_MEAS_DIGITAL = 2'h2,
        RRGD_MEAS_UNUSED  = 2'h3
    } rrgd_meas_t;
endpackage

// file: core/rrgd_peak_hold.sv
// one channel peak holder for a four-bit strength code
// assumes the detector code is synchronous to clk
`timescale 1ns/100ps
module rrgd_peak_hold #(
    parameter int CODE_W = 4
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // control
    input  wire logic              clear,
    input  wire logic              sample_en,
    input  wire logic [CODE_W-1:0] code_in,
    // result
    output logic      [CODE_W-1:0] peak_r
);
    // codes are a monotonic index, so an unsigned compare finds the peak
    // monotonic compare
    always_ff @(posedge clk)
    begin
        if (srst || clear)
            peak_r <= '0;
        else if (sample_en && (code_in > peak_r))
            peak_r <= code_in;
    end
endmodule // rrgd_peak_hold

// file: core/rrgd_regs.sv
// regulator control, regulator/timer display, strength display,
// gain reduction display and two reserved addresses
// assumes a synchronous single-cycle register port; srst is also driven by
// the set-default command
// reads are registered: read data follows its strobe by one cycle
// strength codes are only compared for peaks, stored and shown here, never decoded
//
// Notes on behaviour
// - source bit 0 takes adjust result code, 1 takes written code
// - written regulator code sits in control bits 6..3
// - measure field 00 main, 01 analog, 10 digital regulator
// - display upper nibble shows regulator code in effect
// - reset and set-default force effective regulator code to all ones
// - display bits 2,1,0 show general, no-response, mask timers running
// - strength register holds AM peak high, PM peak low
// - peaks clear at message start and on clear-strength command
// - strength code is a sixteen-level monotonic index
// - strength and gain displays read zero after reset
// - channel select picks which stored peak logic uses
// - gain register shows AM cut high, PM cut low, msb on top
// - addresses after gain register are reserved, read-only
`timescale 1ns/100ps
module rrgd_regs #(
    parameter int DATA_W = rrgd_pkg::DATA_W,
    parameter int ADDR_W = rrgd_pkg::ADDR_W,
    parameter int CODE_W = rrgd_pkg::CODE_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata_r,
    // regulator
    input  wire logic              adjust_done,
    input  wire logic [CODE_W-1:0] adjust_code,
    output logic      [CODE_W-1:0] reg_code_eff_r,
    output logic      [1:0]        meas_source_r,
    // timers
    input  wire logic              gpt_running,
    input  wire logic              nrt_running,
    input  wire logic              mrt_running,
    // strength detectors
    input  wire logic              strength_valid,
    input  wire logic [CODE_W-1:0] am_strength,
    input  wire logic [CODE_W-1:0] pm_strength,
    input  wire logic              msg_start,
    input  wire logic              clear_strength_cmd,
    input  wire logic              chan_sel_pm,
    output logic      [CODE_W-1:0] strength_used_r,
    // gain reduction
    input  wire logic [CODE_W-1:0] am_gain_cut,
    input  wire logic [CODE_W-1:0] pm_gain_cut
);
    // ************************************************************
    // address decode
    // ************************************************************
    // one compare per register, shared by the write and the read path,
    // so both always agree on what an address means
    logic              sel_ctrl;
    logic              sel_disp;
    logic              sel_strength;
    logic              sel_gain;
    logic              sel_rsvd;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ref_a);
        hit = (a == ref_a);
    endfunction

    assign sel_ctrl     = hit(reg_addr, rrgd_pkg::ADDR_REG_CTRL);
    assign sel_disp     = hit(reg_addr, rrgd_pkg::ADDR_REG_DISP);
    assign sel_strength = hit(reg_addr, rrgd_pkg::ADDR_STRENGTH);
    assign sel_gain     = hit(reg_addr, rrgd_pkg::ADDR_GAIN_CUT);
    assign sel_rsvd     = hit(reg_addr, rrgd_pkg::ADDR_RSVD_A)
                       || hit(reg_addr, rrgd_pkg::ADDR_RSVD_B);

    // ************************************************************
    // word packing helpers
    // ************************************************************
    // two channel nibbles into one byte, first argument on top;
    // assumes two nibbles fill the data width exactly
    function automatic logic [DATA_W-1:0] pack_pair(
        input logic [CODE_W-1:0] hi,
        input logic [CODE_W-1:0] lo
    );
        pack_pair = {hi, lo};
    endfunction

    // regulator code on top, one spare zero bit, then the timer flags
    function automatic logic [DATA_W-1:0] pack_disp(
        input logic [CODE_W-1:0] code,
        input logic              gpt,
        input logic              nrt,
        input logic              mrt
    );
        pack_disp = {code, 1'b0, gpt, nrt, mrt};
    endfunction

    // ************************************************************
    // control register
    // ************************************************************
    logic [DATA_W-1:0] ctrl_r;
    logic [CODE_W-1:0] adjust_code_r;
    logic              wr_ctrl;

    // only control is writable
    // write data is never looked at outside the control address
    assign wr_ctrl = reg_wr && sel_ctrl;

    // bit 0 has no function; the mask keeps it reading zero
    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl_r <= rrgd_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl_r <= reg_wdata & rrgd_pkg::CTRL_WR_MASK;
    end

    // last adjust result; starts at maximum
    // kept while the written code is in force, so clearing the source
    // bit falls straight back to the latest adjustment
    always_ff @(posedge clk)
    begin
        if (srst)
            adjust_code_r <= rrgd_pkg::REG_CODE_MAX;
        else if (adjust_done)
            adjust_code_r <= adjust_code;
    end

    // ************************************************************
    // control register fields
    // ************************************************************
    logic              src_is_ext;
    logic [CODE_W-1:0] ext_code;
    logic [1:0]        meas_field;

    assign src_is_ext = ctrl_r[rrgd_pkg::CTRL_SRC_BIT];
    assign ext_code   = ctrl_r[rrgd_pkg::CTRL_CODE_HI:rrgd_pkg::CTRL_CODE_LO];
    assign meas_field = ctrl_r[rrgd_pkg::CTRL_MEAS_HI:rrgd_pkg::CTRL_MEAS_LO];

    // ************************************************************
    // effective regulator code and measure source
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
            reg_code_eff_r <= rrgd_pkg::REG_CODE_MAX;
        else if (src_is_ext)
            reg_code_eff_r <= ext_code;
        else
            reg_code_eff_r <= adjust_code_r;
    end

    // measure source routing
    // code 11 has no source of its own; it is passed on unchanged and
    // the supply measurement decides what to do with it
    rrgd_pkg::rrgd_meas_t meas_route;

    always_comb
    begin
        meas_route = rrgd_pkg::RRGD_MEAS_MAIN;
        unique case (meas_field)
            rrgd_pkg::RRGD_MEAS_MAIN:    meas_route = rrgd_pkg::RRGD_MEAS_MAIN;
            rrgd_pkg::RRGD_MEAS_ANALOG:  meas_route = rrgd_pkg::RRGD_MEAS_ANALOG;
            rrgd_pkg::RRGD_MEAS_DIGITAL: meas_route = rrgd_pkg::RRGD_MEAS_DIGITAL;
            rrgd_pkg::RRGD_MEAS_UNUSED:  meas_route = rrgd_pkg::RRGD_MEAS_UNUSED;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            meas_source_r <= rrgd_pkg::RRGD_MEAS_MAIN;
        else
            meas_source_r <= meas_route;
    end

    // ************************************************************
    // strength peaks
    // ************************************************************
    logic [CODE_W-1:0] am_peak;
    logic [CODE_W-1:0] pm_peak;
    logic              peak_clear;

    // clear on message start or command
    // a clear wins over a sample in the same cycle, so a new message
    // never starts with the peak of the one before
    // both channels share one clear and one sample strobe
    assign peak_clear = msg_start || clear_strength_cmd;

    rrgd_peak_hold #(.CODE_W(CODE_W)) u_am_peak (
        .clk       (clk),
        .srst      (srst),
        .clear     (peak_clear),
        .sample_en (strength_valid),
        .code_in   (am_strength),
        .peak_r    (am_peak)
    );

    rrgd_peak_hold #(.CODE_W(CODE_W)) u_pm_peak (
        .clk       (clk),
        .srst      (srst),
        .clear     (peak_clear),
        .sample_en (strength_valid),
        .code_in   (pm_strength),
        .peak_r    (pm_peak)
    );

    // channel pick
    // registered for a clean output; it trails a new peak by one cycle
    always_ff @(posedge clk)
    begin
        if (srst)
            strength_used_r <= rrgd_pkg::CODE_ZERO;
        else
            strength_used_r <= chan_sel_pm ? pm_peak : am_peak;
    end

    // ************************************************************
    // gain reduction capture
    // ************************************************************
    logic [CODE_W-1:0] am_cut_r;
    logic [CODE_W-1:0] pm_cut_r;

    // captured every cycle, so a read shows the cut of the cycle before
    // its strobe and never a value changing under the read
    // zero after reset
    always_ff @(posedge clk)
    begin
        if (srst)
            am_cut_r <= rrgd_pkg::CODE_ZERO;
        else
            am_cut_r <= am_gain_cut;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            pm_cut_r <= rrgd_pkg::CODE_ZERO;
        else
            pm_cut_r <= pm_gain_cut;
    end

    // ************************************************************
    // read words
    // ************************************************************
    // words are built here so that the read mux only selects
    logic [DATA_W-1:0] disp_word;
    logic [DATA_W-1:0] strength_word;
    logic [DATA_W-1:0] gain_word;

    // code on top, timer flags live at the read edge
    assign disp_word     = pack_disp(reg_code_eff_r, gpt_running, nrt_running, mrt_running);
    // AM peak high, PM peak low
    assign strength_word = pack_pair(am_peak, pm_peak);
    // AM cut high, PM cut low, msb on top
    assign gain_word     = pack_pair(am_cut_r, pm_cut_r);

    // ************************************************************
    // read port
    // ************************************************************
    logic [DATA_W-1:0] rd_mux;

    always_comb
    begin
        rd_mux = rrgd_pkg::BYTE_ZERO;
        unique case (1'b1)
            sel_ctrl:
                rd_mux = ctrl_r;
            sel_disp:
                rd_mux = disp_word;
            sel_strength:
                rd_mux = strength_word;
            sel_gain:
                rd_mux = gain_word;
            sel_rsvd:
                rd_mux = rrgd_pkg::BYTE_ZERO;
            // unmapped addresses read zero as well
            default:
                rd_mux = rrgd_pkg::BYTE_ZERO;
        endcase
    end

    // read data holds until the next read strobe, so a host may fetch it late
    always_ff @(posedge clk)
    begin
        if (srst)
            reg_rdata_r <= rrgd_pkg::BYTE_ZERO;
        else if (reg_rd)
            reg_rdata_r <= rd_mux;
    end
endmodule // rrgd_regs

// file: tb/rrgd_regs_sva.sv
// concurrent checks on the ports of the regulator/strength/gain register bank
// assumes it is bound to rrgd_regs by the bench top file
`timescale 1ns/100ps
module rrgd_regs_sva (
    // clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // register port
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r,
    // regulator
    input wire logic [3:0] reg_code_eff_r,
    input wire logic [1:0] meas_source_r,
    // timers
    input wire logic       gpt_running,
    input wire logic       nrt_running,
    input wire logic       mrt_running,
    // strength
    input wire logic       strength_valid,
    input wire logic [3:0] am_strength,
    input wire logic [3:0] pm_strength,
    input wire logic       msg_start,
    input wire logic       clear_strength_cmd,
    input wire logic       chan_sel_pm,
    input wire logic [3:0] strength_used_r,
    // gain reduction
    input wire logic [3:0] am_gain_cut,
    input wire logic [3:0] pm_gain_cut
);
    // ****************************************************************
    // port properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_code_max:
    assert property ($fell(srst) |-> reg_code_eff_r == 4'hf && strength_used_r == 4'h0)
        else $error("regulator code or strength not cleared by reset");
    a_reserved_zero:
    assert property (reg_rd && reg_addr[5:1] == 5'h17 |=> reg_rdata_r == 8'h00)
        else $error("reserved address read not zero");
    a_display_live:
    assert property (reg_rd && reg_addr == 6'h2b |=> reg_rdata_r == {$past(reg_code_eff_r),
        1'b0, $past(gpt_running), $past(nrt_running), $past(mrt_running)})
        else $error("regulator and timer display wrong");
    a_gain_view:
    assert property (reg_rd && reg_addr == 6'h2d && !$past(srst) |=>
        reg_rdata_r == {$past(am_gain_cut, 2), $past(pm_gain_cut, 2)})
        else $error("gain reduction display wrong");
    a_ext_code:
    assert property (reg_wr && reg_addr == 6'h2a && reg_wdata[7] ##1 !reg_wr |=>
        reg_code_eff_r == $past(reg_wdata[6:3], 2)) else $error("written code not in effect");
    a_meas_route:
    assert property (reg_wr && reg_addr == 6'h2a ##1 !reg_wr [*2] |=>
        meas_source_r == $past(reg_wdata[2:1], 3)) else $error("measure source wrong");
    a_peak_clear:
    assert property ((msg_start || clear_strength_cmd) ##1 !strength_valid [*2] |=>
        strength_used_r == 4'h0) else $error("peak not cleared");
    a_peak_keep:
    assert property (strength_valid && !msg_start && !clear_strength_cmd &&
        !$past(msg_start || clear_strength_cmd) ##1 !msg_start && !clear_strength_cmd &&
        $stable(chan_sel_pm) |=> strength_used_r >= $past(chan_sel_pm ? pm_strength :
        am_strength, 2)) else $error("peak below a sampled code");
endmodule // rrgd_regs_sva

// file: tb/rrgd_regs_tb.sv
// self-checking bench for the regulator/strength/gain register bank
// assumes rrgd_pkg, rrgd_regs and the checker are compiled first
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module rrgd_regs_tb;
    typedef struct packed { logic [7:0] wd; logic [3:0] eff; logic [1:0] ms; } rrgd_row_t;
    logic       clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, adjust_done = 0;
    logic       gpt_running = 0, nrt_running = 0, mrt_running = 0, strength_valid = 0;
    logic       msg_start = 0, clear_strength_cmd = 0, chan_sel_pm = 0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata_r, rd_val;
    logic [3:0] adjust_code = 4'h0, am_strength = 4'h0, pm_strength = 4'h0;
    logic [3:0] am_gain_cut = 4'h0, pm_gain_cut = 4'h0, reg_code_eff_r, strength_used_r;
    logic [1:0] meas_source_r;
    logic [7:0] smp [3] = '{8'h38, 8'h92, 8'h14};
    int         fails = 0, n_checks = 0;
    rrgd_row_t  rows [4] = '{'{8'hb8, 4'h7, 2'h0}, '{8'hd2, 4'ha, 2'h1},
                             '{8'he4, 4'hc, 2'h2}, '{8'h04, 4'hf, 2'h2}};
    always #10 clk = ~clk;
    rrgd_regs dut (.clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r,
        .adjust_done, .adjust_code, .reg_code_eff_r, .meas_source_r, .gpt_running,
        .nrt_running, .mrt_running, .strength_valid, .am_strength, .pm_strength, .msg_start,
        .clear_strength_cmd, .chan_sel_pm, .strength_used_r, .am_gain_cut, .pm_gain_cut);
    // ****************************************************************
    // register port tasks, entered at a falling edge
    // ****************************************************************
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk) reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk) reg_rd = 1'b0;
        rd_val = reg_rdata_r;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d, errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        tick(4);
        srst = 1'b0;
        `CHK(reg_code_eff_r, 4'hf)
        rd(6'h2c);
        `CHK(rd_val, 8'h00)
        foreach (rows[i])
        begin
            wr(6'h2a, rows[i].wd);
            rd(6'h2a);
            `CHK(rd_val, rows[i].wd & 8'hfe)
            rd(6'h2b);
            `CHK(rd_val[7:4], rows[i].eff)
            `CHK(meas_source_r, rows[i].ms)
        end
        // adjust result is in effect only while the source bit is clear
        adjust_code = 4'h9;
        for (int k = 0; k < 2; k++)
        begin
            adjust_done = 1'b1;
            tick(1);
            adjust_done = 1'b0;
            tick(2);
            `CHK(reg_code_eff_r, k ? 4'h1 : 4'h9)
            wr(6'h2a, 8'h88);
        end
        {gpt_running, nrt_running, mrt_running} = 3'b110;
        {am_gain_cut, pm_gain_cut} = 8'h5a;
        tick(2);
        rd(6'h2b);
        `CHK(rd_val, 8'h16)
        rd(6'h2d);
        `CHK(rd_val, 8'h5a)
        strength_valid = 1'b1;
        foreach (smp[i])
        begin
            {am_strength, pm_strength} = smp[i];
            tick(1);
        end
        strength_valid = 1'b0;
        tick(2);
        `CHK(strength_used_r, 4'h9)
        chan_sel_pm = 1'b1;
        // display, strength, gain and reserved places ignore writes
        for (int a = 'h2b; a <= 'h2f; a++)
            wr(a[5:0], 8'hff);
        `CHK(strength_used_r, 4'h8)
        rd(6'h2c);
        `CHK(rd_val, 8'h98)
        rd(6'h2e);
        `CHK(rd_val, 8'h00)
        rd(6'h00);
        `CHK(rd_val, 8'h00)
        rd(6'h2a);
        `CHK(rd_val, 8'h88)
        for (int k = 0; k < 2; k++)
        begin
            {msg_start, clear_strength_cmd} = k ? 2'b10 : 2'b01;
            tick(1);
            {msg_start, clear_strength_cmd} = 2'b00;
            tick(2);
            rd(6'h2c);
            `CHK(rd_val, 8'h00)
            {am_strength, pm_strength, strength_valid} = 9'h0cd;
            tick(1);
            strength_valid = 1'b0;
        end
        srst = 1'b1;
        tick(1);
        srst = 1'b0;
        `CHK(reg_code_eff_r, 4'hf)
        rd(6'h2a);
        `CHK(rd_val, 8'h00)
        complete_run();
    end
endmodule // rrgd_regs_tb
bind rrgd_regs rrgd_regs_sva u_sva (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_r, .reg_code_eff_r, .am_strength, .pm_strength, .strength_used_r, .am_gain_cut,
    .pm_gain_cut, .meas_source_r, .gpt_running, .nrt_running, .mrt_running, .strength_valid,
    .msg_start, .clear_strength_cmd, .chan_sel_pm);
